// ### asc_command_unit.sv
// serial command unit of a magnetic angle sensor: frame capture, command handling, fault status
// assumes an external master drives sck and ssN; measurement datapath signals are on core_clk
`timescale 1ns/1ps
`default_nettype none
module asc_command_unit
	import asc_pkg::*;
(
	input wire logic core_clk, // core clock, 125 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic sck, // serial clock from master
	input wire logic ssN, // slave select, active low
	input wire logic mosi, // serial data in
	output var logic miso, // serial data out
	output var logic misoOe, // miso drive enable
	input wire logic [9:0] angleValue, // measured angle
	input wire logic hallFieldOverflow, // field too strong
	input wire logic angleCalcOverflow, // angle computation overflow
	input wire logic currentSourceRangeError, // current source range fault
	input wire logic gainMinimumFlag, // gain at or below minimum
	input wire logic gainMaximumFlag, // gain at or above maximum
	input wire logic measBusy, // measuring
	input wire logic asleep, // oscillator stopped
	input wire logic measDone, // measurement finished pulse
	output logic measStart_q, // angle read pulse to datapath
	output logic coreReset_q, // digital core reset pulse
	output logic otpReload_q, // fuse reload and new conversion pulse
	output logic oscWake_q, // oscillator start pulse
	output logic masterReset_q, // power-on reset injection pulse
	output logic transferErrorFlag_q, // sticky transfer error
	output logic [5:0] agcSetting_q, // gain control register
	output logic [7:0] porOff_q // power-on cell disable register
);
	// link domain: shift in on falling sck, count clocks
	logic [15:0] rxShift_q;
	logic [4:0] bitCnt_q;
	logic fresh_q;
	logic [3:0] txIdx_q;
	logic [15:0] txWord_q;

	always_ff @(negedge sck or posedge ssN or posedge sys_rst) begin
		if (sys_rst || ssN) fresh_q <= 1'b1;
		else fresh_q <= 1'b0;
	end

	always_ff @(negedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			rxShift_q <= 16'h0000;
			bitCnt_q <= 5'h00;
		end else begin
			rxShift_q <= {rxShift_q[14:0], mosi};
			bitCnt_q <= fresh_q ? 5'h01 : (bitCnt_q == CNT_MAX ? CNT_MAX : bitCnt_q + 5'h01);
		end
	end

	// txWord_q only changes while ssN is high, so it is static across the frame
	always_ff @(posedge sck or posedge sys_rst or posedge ssN) begin
		if (sys_rst || ssN) begin
			txIdx_q <= 4'h0;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			misoOe <= 1'b1;
			miso <= txWord_q[4'hF - txIdx_q];
			txIdx_q <= (txIdx_q == 4'hF) ? 4'hF : txIdx_q + 4'h1;
		end
	end

	// core domain: ssN through three flops, frame ends when last two agree high
	logic ssS1_q, ssS2_q, ssS3_q, ssStable_q;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ssS1_q <= 1'b1;
			ssS2_q <= 1'b1;
			ssS3_q <= 1'b1;
			ssStable_q <= 1'b1;
		end else begin
			ssS1_q <= ssN;
			ssS2_q <= ssS1_q;
			ssS3_q <= ssS2_q;
			if (ssS2_q == ssS3_q) ssStable_q <= ssS3_q;
		end
	end

	// rxShift_q and bitCnt_q sit still once sck stops, so they are read here without a synchroniser
	wire frameEnd = ssS2_q && ssS3_q && !ssStable_q;
	wire clkBad = bitCnt_q != FRAME_BITS_C;
	wire parBad = ^rxShift_q;
	wire rxRead = rxShift_q[RW_BIT];
	wire [13:0] rxAddr = rxShift_q[14:1];
	wire [13:0] rxData = rxShift_q[15:2];

	asc_pend_t pend_q;
	logic [13:0] pendAddr_q;
	logic [13:0] status_q;
	logic parityErr_q, clkErr_q, addrErr_q, handshake_q;

	// live fault word; reserved bits 3, 6, 7, 13 read zero
	wire [13:0] faultStatusFlags = {1'b0, gainMaximumFlag, gainMinimumFlag, currentSourceRangeError,
		angleCalcOverflow, hallFieldOverflow, 2'b00, measBusy, handshake_q,
		1'b0, addrErr_q, clkErr_q, parityErr_q};
	wire anyFault = parityErr_q || clkErr_q || addrErr_q || hallFieldOverflow
		|| angleCalcOverflow || currentSourceRangeError;
	wire alarmHi = anyFault || gainMaximumFlag;
	wire alarmLo = anyFault || gainMinimumFlag;
	wire [13:0] angleWord = {alarmHi, alarmLo, 2'b00, angleValue};

	wire isNop = !rxRead && rxAddr == ADDR_NOP;
	wire isClr = rxRead && rxAddr == ADDR_CLRERR;
	wire rdKnown = rxAddr == ADDR_ANGLE || rxAddr == ADDR_STATUS || rxAddr == ADDR_AGC
		|| rxAddr == ADDR_POR || rxAddr == ADDR_CFG || rxAddr == ADDR_CLRERR;
	wire wrKnown = rxAddr == ADDR_SWRST || rxAddr == ADDR_MRST || rxAddr == ADDR_AGC
		|| rxAddr == ADDR_POR || rxAddr == ADDR_NOP;
	wire cmdKnown = rxRead ? rdKnown : wrKnown;
	wire frameOk = frameEnd && !clkBad && !parBad;
	wire dataFrame = frameOk && pend_q == PEND_WRITE;
	wire cmdFrame = frameOk && pend_q == PEND_NONE;
	wire cmdBad = cmdFrame && !cmdKnown;
	wire frameErr = frameEnd && (clkBad || parBad || cmdBad);
	wire clrCmd = cmdFrame && isClr;
	wire swrstData = dataFrame && pendAddr_q == ADDR_SWRST;
	wire resIf = swrstData && rxShift_q[RES_IF_BIT];
	wire angleRd = cmdFrame && rxRead && rxAddr == ADDR_ANGLE;

	// read mux for the answer returned in the following frame
	wire [13:0] rdData = (rxAddr == ADDR_ANGLE) ? angleWord :
		(rxAddr == ADDR_STATUS) ? status_q :
		(rxAddr == ADDR_AGC) ? {8'h00, agcSetting_q} :
		(rxAddr == ADDR_POR) ? {6'h00, porOff_q} :
		(rxAddr == ADDR_CFG) ? {CFG_RES, CFG_ID, 9'h000} : DATA_ZERO;
	wire [13:0] ansData = dataFrame ? rxData :
		(cmdFrame && rxRead && !isClr) ? rdData : DATA_ZERO;
	wire efNext = frameErr || (transferErrorFlag_q && !clrCmd && !resIf);
	wire [14:0] ansBody = {ansData, efNext};

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_q <= PEND_NONE;
			pendAddr_q <= ADDR_NOP;
			transferErrorFlag_q <= 1'b0;
			txWord_q <= 16'h0000;
			parityErr_q <= 1'b0;
			clkErr_q <= 1'b0;
			addrErr_q <= 1'b0;
		end else if (frameEnd) begin
			transferErrorFlag_q <= efNext;
			txWord_q <= {ansBody, ^ansBody};
			// a bad frame drops any half-done write
			pend_q <= (cmdFrame && !rxRead && cmdKnown && !isNop) ? PEND_WRITE : PEND_NONE;
			pendAddr_q <= rxAddr;
			// set wins: a fault in this frame outranks clearing
			// a short or long frame has no parity bit in place: only the clock fault is logged
			parityErr_q <= (parBad && !clkBad) || (parityErr_q && !clrCmd && !resIf);
			clkErr_q <= clkBad || (clkErr_q && !clrCmd && !resIf);
			addrErr_q <= cmdBad || (addrErr_q && !clrCmd && !resIf);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			agcSetting_q <= AGC_RST;
			porOff_q <= POR_RST;
			status_q <= DATA_ZERO;
			handshake_q <= 1'b0;
		end else begin
			status_q <= faultStatusFlags;
			if (angleRd) handshake_q <= 1'b1;
			else if (measDone) handshake_q <= 1'b0;
			if (resIf) begin
				agcSetting_q <= AGC_RST;
				porOff_q <= POR_RST;
			end else if (dataFrame && pendAddr_q == ADDR_AGC) agcSetting_q <= rxData[5:0];
			else if (dataFrame && pendAddr_q == ADDR_POR) porOff_q <= rxData[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			measStart_q <= 1'b0;
			coreReset_q <= 1'b0;
			otpReload_q <= 1'b0;
			oscWake_q <= 1'b0;
			masterReset_q <= 1'b0;
		end else begin
			measStart_q <= angleRd;
			coreReset_q <= swrstData;
			otpReload_q <= swrstData;
			oscWake_q <= swrstData && asleep;
			masterReset_q <= dataFrame && pendAddr_q == ADDR_MRST;
		end
	end

	// checks on core clock
	sequence s_clrFrame;
		frameEnd && clrCmd;
	endsequence
	sequence s_zeroAnswer;
		txWord_q[15:2] == DATA_ZERO && !txWord_q[EF_BIT];
	endsequence
	property p_clrErr;
		@(posedge core_clk) disable iff (sys_rst) s_clrFrame |=> s_zeroAnswer;
	endproperty
	a_clrErr: assert property (p_clrErr) else $error("clear-error did not answer zero");
	property p_faultSets;
		@(posedge core_clk) disable iff (sys_rst) frameEnd && (clkBad || parBad) |=> transferErrorFlag_q;
	endproperty
	a_faultSets: assert property (p_faultSets) else $error("fault did not set error flag");
	property p_sticky;
		@(posedge core_clk) disable iff (sys_rst)
			transferErrorFlag_q && !(frameEnd && (clrCmd || resIf)) |=> transferErrorFlag_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag fell without clear");
	property p_txParity;
		@(posedge core_clk) disable iff (sys_rst) !(^txWord_q);
	endproperty
	a_txParity: assert property (p_txParity) else $error("answer parity odd");
	property p_echo;
		@(posedge core_clk) disable iff (sys_rst) dataFrame |=> txWord_q[15:2] == $past(rxData);
	endproperty
	a_echo: assert property (p_echo) else $error("written data not echoed");
	sequence s_swrst;
		frameEnd && swrstData;
	endsequence
	property p_swrst;
		@(posedge core_clk) disable iff (sys_rst) s_swrst |=> coreReset_q && otpReload_q ##1 !otpReload_q;
	endproperty
	a_swrst: assert property (p_swrst) else $error("software reset pulse wrong");
	property p_handshake;
		@(posedge core_clk) disable iff (sys_rst) angleRd |=> handshake_q && measStart_q;
	endproperty
	a_handshake: assert property (p_handshake) else $error("handshake not raised");
	property p_alarm;
		@(posedge core_clk) disable iff (sys_rst) anyFault |-> angleWord[GAIN_MAXIMUM_FLAG_BIT] && angleWord[GAIN_MINIMUM_FLAG_BIT];
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm pair not both set on fault");
	property p_nopKeep;
		@(posedge core_clk) disable iff (sys_rst)
			cmdFrame && isNop |=> pend_q == PEND_NONE && txWord_q[15:2] == DATA_ZERO;
	endproperty
	a_nopKeep: assert property (p_nopKeep) else $error("nop frame took action");
	// fault bookkeeping, write path and pulse outputs
	sequence s_mrstPulse;
		masterReset_q ##1 !masterReset_q;
	endsequence
	property p_clkStatus;
		@(posedge core_clk) disable iff (sys_rst) frameEnd && clkBad |=> clkErr_q && transferErrorFlag_q;
	endproperty
	a_clkStatus: assert property (p_clkStatus) else $error("clock count fault not logged");
	property p_parStatus;
		@(posedge core_clk) disable iff (sys_rst) frameEnd && parBad && !clkBad |=> parityErr_q;
	endproperty
	a_parStatus: assert property (p_parStatus) else $error("parity fault not logged");
	property p_addrStatus;
		@(posedge core_clk) disable iff (sys_rst) cmdBad |=> addrErr_q && transferErrorFlag_q;
	endproperty
	a_addrStatus: assert property (p_addrStatus) else $error("unknown command not logged");
	property p_gainAlarm;
		@(posedge core_clk) disable iff (sys_rst) angleRd && !anyFault
			|=> txWord_q[15:14] == {$past(gainMaximumFlag), $past(gainMinimumFlag)};
	endproperty
	a_gainAlarm: assert property (p_gainAlarm) else $error("alarm pair does not follow gain flags");
	property p_agcWrite;
		@(posedge core_clk) disable iff (sys_rst)
			dataFrame && pendAddr_q == ADDR_AGC |=> agcSetting_q == $past(rxData[5:0]);
	endproperty
	a_agcWrite: assert property (p_agcWrite) else $error("gain register write lost");
	property p_handshakeEnd;
		@(posedge core_clk) disable iff (sys_rst) measDone && !angleRd |=> !handshake_q;
	endproperty
	a_handshakeEnd: assert property (p_handshakeEnd) else $error("handshake not cleared");
	property p_resIf;
		@(posedge core_clk) disable iff (sys_rst)
			resIf |=> agcSetting_q == AGC_RST && porOff_q == POR_RST && !transferErrorFlag_q;
	endproperty
	a_resIf: assert property (p_resIf) else $error("interface registers not reset");
	property p_wake;
		@(posedge core_clk) disable iff (sys_rst) swrstData && asleep |=> oscWake_q;
	endproperty
	a_wake: assert property (p_wake) else $error("oscillator not woken");
	property p_masterReset;
		@(posedge core_clk) disable iff (sys_rst) dataFrame && pendAddr_q == ADDR_MRST |=> s_mrstPulse;
	endproperty
	a_masterReset: assert property (p_masterReset) else $error("master reset pulse wrong");
	property p_writePend;
		@(posedge core_clk) disable iff (sys_rst)
			cmdFrame && !rxRead && wrKnown && rxAddr != ADDR_NOP |=> pend_q == PEND_WRITE;
	endproperty
	a_writePend: assert property (p_writePend) else $error("write command not held for data");
	property p_dataEnds;
		@(posedge core_clk) disable iff (sys_rst) dataFrame |=> pend_q == PEND_NONE;
	endproperty
	a_dataEnds: assert property (p_dataEnds) else $error("frame after data not taken as command");
endmodule : asc_command_unit
`default_nettype wire

// ### asc_command_unit_bench.sv
// self-checking bench for the serial command unit
// assumes the master model above; answers checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module asc_command_unit_bench;
	import asc_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sck, ssN, mosi, miso, misoOe, rxValid;
	logic [15:0] rxWord;
	logic [9:0] angleValue = 10'h000;
	logic gMin = 1'b0, gMax = 1'b0, measBusy = 1'b0, asleep = 1'b1, measDone = 1'b0;
	logic hallOv = 1'b0, calcOv = 1'b0, rangeErr = 1'b0;
	logic measStart, coreReset, otpReload, oscWake, masterReset, errFlag;
	logic [5:0] agc;
	logic [7:0] porOff;
	logic [16:0] expQ [$];
	int nFail = 0, nTests = 0, nWake = 0, nReload = 0, nStart = 0, nCore = 0, nMaster = 0;
	always #4 core_clk = ~core_clk;
	asc_command_unit asc_command_unit_inst (.core_clk(core_clk), .sys_rst(sys_rst), .sck(sck), .ssN(ssN),
		.mosi(mosi), .miso(miso), .misoOe(misoOe), .angleValue(angleValue), .hallFieldOverflow(hallOv),
		.angleCalcOverflow(calcOv), .currentSourceRangeError(rangeErr), .gainMinimumFlag(gMin),
		.gainMaximumFlag(gMax), .measBusy(measBusy), .asleep(asleep), .measDone(measDone),
		.measStart_q(measStart), .coreReset_q(coreReset), .otpReload_q(otpReload), .oscWake_q(oscWake),
		.masterReset_q(masterReset), .transferErrorFlag_q(errFlag), .agcSetting_q(agc), .porOff_q(porOff));
	asc_spi_master asc_spi_master_inst (.sck(sck), .ssN(ssN), .mosi(mosi), .miso(miso),
		.rxWord(rxWord), .rxValid(rxValid));
	function automatic logic [15:0] pw(input logic [14:0] x);
		return {x, ^x};
	endfunction : pw
	task automatic fr(input logic [15:0] w, input int n, input logic [16:0] e);
		expQ.push_back(e);
		asc_spi_master_inst.xfer(w, n);
	endtask : fr
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		nTests++;
		if (got !== want) begin
			nFail++;
			$display("ERROR %0t port value %h expected %h", $time, got, want);
		end
	endtask : chk
	// bit 16 of a note marks a checked answer; the rest are don't care
	always @(posedge rxValid) begin
		logic [16:0] e;
		e = expQ.pop_front();
		if (e[16]) begin
			nTests++;
			if (rxWord !== e[15:0]) begin
				nFail++;
				$display("ERROR %0t answer %h expected %h", $time, rxWord, e[15:0]);
			end
		end
	end
	always @(posedge core_clk) begin
		if (oscWake === 1'b1) nWake++;
		if (otpReload === 1'b1) nReload++;
		if (measStart === 1'b1) nStart++;
		if (coreReset === 1'b1) nCore++;
		if (masterReset === 1'b1) nMaster++;
	end
	task automatic summarize();
		$display("tests %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial begin
		#300000;
		nFail++;
		$display("ERROR %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		int seed;
		logic [13:0] d;
		logic [15:0] badW [4];
		int nClk [4];
		logic [13:0] stBit [4];
		logic [2:0] f;
		logic [7:0] p;
		seed = 32'hDAAB29DE;
		badW = '{16'h0001, pw({1'b1, ADDR_STATUS}), pw({1'b1, ADDR_STATUS}), pw({1'b1, 14'h1234})};
		nClk = '{16, 15, 17, 16};
		stBit = '{14'h0001, 14'h0002, 14'h0002, 14'h0004};
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		fr(16'h0000, 16, 17'h00000);
		fr(pw({1'b1, ADDR_AGC}), 16, {1'b1, pw(15'h0000)});
		fr(pw({1'b0, ADDR_AGC}), 16, {1'b1, pw({14'h0020, 1'b0})});
		d = {8'h00, 6'($random(seed))};
		fr(pw({d, 1'b0}), 16, 17'h00000);
		fr(16'h0000, 16, {1'b1, pw({d, 1'b0})});
		fr(pw({1'b1, ADDR_AGC}), 16, 17'h00000);
		fr(16'h0000, 16, {1'b1, pw({d, 1'b0})});
		chk({10'h000, agc}, {10'h000, d[5:0]});
		chk({15'h0000, misoOe}, 16'h0000);
		$display("test register access done");
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			angleValue <= 10'($random(seed));
			gMin <= (i == 1);
			gMax <= (i == 2);
			fr(pw({1'b1, ADDR_ANGLE}), 16, 17'h00000);
			fr(16'h0000, 16, {1'b1, pw({i == 2, i == 1, 2'b00, angleValue, 1'b0})});
		end
		@(posedge core_clk);
		gMin <= 1'b0;
		gMax <= 1'b0;
		measDone <= 1'b1;
		measBusy <= 1'b1;
		@(posedge core_clk);
		measDone <= 1'b0;
		fr(pw({1'b1, ADDR_STATUS}), 16, 17'h00000);
		fr(16'h0000, 16, {1'b1, pw({14'h0020, 1'b0})});
		@(posedge core_clk);
		measBusy <= 1'b0;
		$display("test angle and status done");
		// each fault: refused frame, status read, clear, clean answer
		for (int i = 0; i < 4; i++) begin
			fr(badW[i], nClk[i], 17'h00000);
			chk({15'h0000, errFlag}, 16'h0001);
			fr(pw({1'b1, ADDR_STATUS}), 16, {1'b1, pw({14'h0000, 1'b1})});
			fr(pw({1'b1, ADDR_CLRERR}), 16, {1'b1, pw({stBit[i], 1'b1})});
			chk({15'h0000, errFlag}, 16'h0000);
			fr(16'h0000, 16, {1'b1, pw(15'h0000)});
		end
		$display("test fault handling done");
		@(posedge core_clk);
		f = 3'($random(seed)) | 3'h1;
		hallOv <= f[0];
		calcOv <= f[1];
		rangeErr <= f[2];
		fr(pw({1'b1, ADDR_STATUS}), 16, 17'h00000);
		fr(pw({1'b1, ADDR_ANGLE}), 16, {1'b1, pw({3'b000, f, 8'h00, 1'b0})});
		fr(16'h0000, 16, {1'b1, pw({|f, |f, 2'b00, angleValue, 1'b0})});
		@(posedge core_clk);
		hallOv <= 1'b0;
		calcOv <= 1'b0;
		rangeErr <= 1'b0;
		$display("test field faults done");
		p = 8'($random(seed));
		fr(pw({1'b0, ADDR_POR}), 16, 17'h00000);
		fr(pw({6'h00, p, 1'b0}), 16, 17'h00000);
		fr(pw({1'b1, ADDR_POR}), 16, {1'b1, pw({6'h00, p, 1'b0})});
		fr(pw({1'b1, ADDR_CFG}), 16, {1'b1, pw({6'h00, p, 1'b0})});
		fr(pw({1'b0, ADDR_MRST}), 16, {1'b1, pw({CFG_RES, CFG_ID, 9'h000, 1'b0})});
		fr(16'h0000, 16, {1'b1, pw(15'h0000)});
		chk({8'h00, porOff}, {8'h00, p});
		$display("test configuration access done");
		d = {8'h00, 6'($random(seed))};
		fr(pw({1'b0, ADDR_AGC}), 16, 17'h00000);
		fr(pw({d, 1'b0}), 16, 17'h00000);
		fr(pw({1'b0, ADDR_SWRST}), 16, {1'b1, pw({d, 1'b0})});
		fr(pw(15'h0002), 16, 17'h00000);
		fr(pw({1'b1, ADDR_AGC}), 16, 17'h00000);
		fr(16'h0000, 16, {1'b1, pw({14'h0020, 1'b0})});
		chk({8'h00, porOff}, {8'h00, POR_RST});
		nTests++;
		if (nWake !== 1 || nReload !== 1) begin
			nFail++;
			$display("ERROR %0t reset pulses wake %0d reload %0d", $time, nWake, nReload);
		end
		chk(16'(nStart), 16'h0004);
		chk(16'(nCore), 16'h0001);
		chk(16'(nMaster), 16'h0001);
		$display("test software reset done");
		summarize();
	end
endmodule : asc_command_unit_bench
`default_nettype wire

// ### asc_pkg.sv
// constants for the angle sensor serial command unit
// assumes a 16-bit frame, msb first, even parity over the whole frame
package asc_pkg;
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_C = 5'h10;
	localparam logic [4:0] CNT_MAX = 5'h1F;
	localparam int DATA_W = 14;
	localparam int RW_BIT = 15;
	localparam int PAR_BIT = 0;
	localparam int EF_BIT = 1;
	localparam int RES_IF_BIT = 2;
	localparam logic [13:0] ADDR_NOP = 14'h0000;
	localparam logic [13:0] ADDR_POR = 14'h3F22;
	localparam logic [13:0] ADDR_SWRST = 14'h3C00;
	localparam logic [13:0] ADDR_MRST = 14'h33A5;
	localparam logic [13:0] ADDR_CLRERR = 14'h3380;
	localparam logic [13:0] ADDR_AGC = 14'h03F8;
	localparam logic [13:0] ADDR_ANGLE = 14'h3FFF;
	localparam logic [13:0] ADDR_STATUS = 14'h335A;
	localparam logic [13:0] ADDR_CFG = 14'h3F20;
	localparam logic [5:0] AGC_RST = 6'h20;
	localparam logic [7:0] POR_RST = 8'h00;
	localparam logic [1:0] CFG_RES = 2'h1;
	localparam logic [2:0] CFG_ID = 3'h5; // arbitrary silicon version value
	localparam logic [13:0] DATA_ZERO = 14'h0000;
	// fault status bit positions, then the alarm bit positions of the angle word
	localparam int ST_PARITY = 0;
	localparam int ST_CLK = 1;
	localparam int ST_ADDR = 2;
	localparam int ST_HAND = 4;
	localparam int ST_MODE = 5;
	localparam int ST_HALL = 8;
	localparam int ST_CALC = 9;
	localparam int ST_RANGE = 10;
	localparam int ST_GLO = 11;
	localparam int ST_GHI = 12;
	localparam int GAIN_MINIMUM_FLAG_BIT = 12;
	localparam int GAIN_MAXIMUM_FLAG_BIT = 13;
	typedef enum {PEND_NONE, PEND_WRITE} asc_pend_t;
endpackage : asc_pkg

// ### asc_spi_master.sv
// host-side serial master model for the command unit
// assumes a 30 ns sck that runs only inside frames, idle low
`timescale 1ns/1ps
`default_nettype none
module asc_spi_master (
	output logic sck, // serial clock
	output logic ssN, // slave select, active low
	output logic mosi, // serial data out
	input wire logic miso, // serial data in
	output logic [15:0] rxWord, // word captured in last frame
	output logic rxValid // pulse after each frame
);
	initial begin
		sck = 1'b0;
		ssN = 1'b1;
		mosi = 1'b0;
		rxValid = 1'b0;
		rxWord = 16'h0000;
	end
	// n other than 16 is used on purpose to provoke a clock count fault
	task automatic xfer(input logic [15:0] w, input int n);
		logic [15:0] rx;
		rx = 16'h0000;
		ssN = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			sck = 1'b1;
			mosi = (i < 16) ? w[15 - i] : 1'b0;
			#15;
			sck = 1'b0;
			rx = {rx[14:0], miso};
			#15;
		end
		#15;
		ssN = 1'b1;
		mosi = ~mosi; // released line shows no stale value
		rxWord = rx;
		rxValid = 1'b1;
		#1;
		rxValid = 1'b0;
		#100;
	endtask : xfer
endmodule : asc_spi_master
`default_nettype wire
